// [csb_chip_select.sv]
`include "csb_params.svh"
`default_nettype none

// Contract
// R01: Area mode 0 maps block over whole 16 MB; mode 1 uses area registers.
// R02: Dummy bit 0 adds no idle cycle after access; 1 adds one.
// R03: Bus width 00 is 8-bit, 01 is 16-bit; 10 and 11 reserved.
// R04: Block 3 write wait code 001, 101, 111 gives 0, 2, 4 waits.
// R05: Block 3 read wait code 001, 101, 111 gives 0, 2, 4 waits.
// R06: Wait count stretches each external cycle by that many clocks.
module csb_chip_select (
    input wire logic clock,                               // 25 MHz system clock
    input wire logic arst_n,                              // Async reset, active low
    input wire logic [`CSB_REG_ADDR_W-1:0] reg_addr,      // Register address
    input wire logic [7:0] reg_wdata,                     // Register write data
    input wire logic reg_write,                           // Register write strobe
    input wire logic reg_read,                            // Register read strobe
    output logic [7:0] reg_rdata,                         // Read data, cycle after strobe
    input wire logic mem_req,                             // Access request pulse
    input wire csb_pkg::csb_req_t mem_req_data,           // Address, direction, data
    output logic mem_ack,                                 // Access finished pulse
    output logic mem_miss,                                // Last request hit no block
    output logic mem_busy,                                // Access in progress
    output logic [15:0] mem_rdata,                        // Read data of finished access
    output logic [1:0] ext_cs_n,                          // Chip selects, block 2 and 3
    output logic ext_rd_n,                                // Read strobe
    output logic ext_wr_n,                                // Write strobe
    output logic [`CSB_EXT_ADDR_W-1:0] ext_addr,          // External address
    output logic [15:0] ext_data_out,                     // Data bus drive value
    output logic ext_data_oe,                             // Data bus drive enable
    input wire logic [15:0] ext_data_in,                  // Data bus sampled value
    input wire logic ext_wait_n                           // Wait pin, low holds cycle
);
    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [7:0] ctrl_high [`CSB_NUM_BLOCKS], ctrl_low [`CSB_NUM_BLOCKS];
    logic [7:0] area_start [`CSB_NUM_BLOCKS], area_mask [`CSB_NUM_BLOCKS];
    csb_pkg::csb_cfg_t cfg [`CSB_NUM_BLOCKS];
    logic [`CSB_NUM_BLOCKS-1:0] hit;
    genvar gi;
    generate
        for (gi = 0; gi < `CSB_NUM_BLOCKS; gi++)
        begin : g_block
            localparam OFS_LOW = (gi == 0) ? `CSB_OFS_B2_LOW : `CSB_OFS_B3_LOW;
            localparam OFS_HIGH = (gi == 0) ? `CSB_OFS_B2_HIGH : `CSB_OFS_B3_HIGH;
            localparam OFS_START = (gi == 0) ? `CSB_OFS_B2_START : `CSB_OFS_B3_START;
            localparam OFS_MASK = (gi == 0) ? `CSB_OFS_B2_MASK : `CSB_OFS_B3_MASK;
            logic [7:0] next_high, next_low, next_start, next_mask, top_byte;
            always_comb
            begin
                next_high = ctrl_high[gi];
                next_low = ctrl_low[gi];
                next_start = area_start[gi];
                next_mask = area_mask[gi];
                if (reg_write)
                begin
                    // Bit 5 is kept at zero whatever is written
                    if (reg_addr == OFS_HIGH)
                        next_high = reg_wdata & ~(8'h01 << `CSB_HI_ZERO_BIT);
                    if (reg_addr == OFS_LOW)
                        next_low = reg_wdata;
                    if (reg_addr == OFS_START)
                        next_start = reg_wdata;
                    if (reg_addr == OFS_MASK)
                        next_mask = reg_wdata;
                end
            end

            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    ctrl_high[gi] <= `CSB_RST_HIGH;
                    ctrl_low[gi] <= `CSB_RST_LOW;
                    area_start[gi] <= `CSB_RST_START;
                    area_mask[gi] <= `CSB_RST_MASK;
                end
                else
                begin
                    ctrl_high[gi] <= next_high;
                    ctrl_low[gi] <= next_low;
                    area_start[gi] <= next_start;
                    area_mask[gi] <= next_mask;
                end
            end

            assign cfg[gi] = '{
                enable: ctrl_high[gi][`CSB_HI_ENABLE],
                area_mode: ctrl_high[gi][`CSB_HI_AREA_MODE],
                dummy: ctrl_high[gi][`CSB_HI_DUMMY],
                mem_type: ctrl_high[gi][`CSB_HI_TYPE_LSB +: 2],
                bus_width: ctrl_high[gi][`CSB_HI_BUS_LSB +: 2],
                write_wait: ctrl_low[gi][`CSB_LO_WW_LSB +: 3],
                read_wait: ctrl_low[gi][`CSB_LO_WR_LSB +: 3],
                area_start: area_start[gi], area_mask: area_mask[gi]
            };

            // R01: fixed 16 MB or programmed area
            assign top_byte = mem_req_data.addr[`CSB_AREA_HI_LSB +: 8];
            assign hit[gi] = cfg[gi].enable && (!cfg[gi].area_mode ||
                (((top_byte ^ cfg[gi].area_start) & ~cfg[gi].area_mask) == 8'h00));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Wait decode

    // R04: R05: wait code to cycle count
    function automatic logic [2:0] wait_count(input logic [2:0] code);
        case (code)
            `CSB_WAIT_CODE_0: wait_count = 3'h0;
            `CSB_WAIT_CODE_1: wait_count = 3'h1;
            `CSB_WAIT_CODE_2: wait_count = 3'h2;
            `CSB_WAIT_CODE_3: wait_count = 3'h3;
            `CSB_WAIT_CODE_4: wait_count = 3'h4;
            default: wait_count = 3'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // External access sequencer

    csb_pkg::csb_state_t state, next_state;
    logic blk, next_blk, beat, next_beat, req_sel, narrow;
    logic next_ack, next_miss, next_busy, next_rd_n, next_wr_n, next_oe;
    logic [2:0] cnt, next_cnt, act_code;
    logic [15:0] wdata_q, next_wdata_q, next_rdata, next_dout;
    logic [1:0] next_cs_n;
    logic [`CSB_EXT_ADDR_W-1:0] next_addr;
    // Lower block wins when both areas overlap
    assign req_sel = !hit[0];
    // Reserved widths fall back to byte cycles
    assign narrow = (cfg[blk].bus_width != `CSB_BUS_16);
    assign act_code = ext_rd_n ? cfg[blk].write_wait : cfg[blk].read_wait;
    always_comb
    begin
        next_state = state;
        next_blk = blk;
        next_cnt = cnt;
        next_beat = beat;
        next_wdata_q = wdata_q;
        next_ack = 1'b0;
        next_miss = mem_miss;
        next_busy = mem_busy;
        next_rdata = mem_rdata;
        next_cs_n = ext_cs_n;
        next_rd_n = ext_rd_n;
        next_wr_n = ext_wr_n;
        next_addr = ext_addr;
        next_dout = ext_data_out;
        next_oe = ext_data_oe;
        case (state)
            csb_pkg::CSB_ST_IDLE:
            begin
                if (mem_req && (hit == 2'b00))
                begin
                    next_ack = 1'b1;
                    next_miss = 1'b1;
                    next_rdata = 16'h0000;
                end
                else if (mem_req)
                begin
                    next_blk = req_sel;
                    next_cnt = wait_count(mem_req_data.write ?
                        cfg[req_sel].write_wait : cfg[req_sel].read_wait);
                    next_beat = 1'b0;
                    next_wdata_q = mem_req_data.wdata;
                    next_miss = 1'b0;
                    next_busy = 1'b1;
                    next_cs_n = req_sel ? 2'b01 : 2'b10;
                    next_rd_n = mem_req_data.write;
                    next_wr_n = !mem_req_data.write;
                    next_addr = mem_req_data.addr;
                    next_dout = mem_req_data.wdata;
                    next_oe = mem_req_data.write;
                    next_state = csb_pkg::CSB_ST_ACCESS;
                end
            end
            csb_pkg::CSB_ST_ACCESS:
            begin
                // R06: hold strobe for the wait count
                if (cnt != 3'h0)
                    next_cnt = cnt - 3'h1;
                else if ((act_code != `CSB_WAIT_CODE_PIN) || ext_wait_n)
                begin
                    // R03: byte bus takes low then high byte
                    if (narrow && !beat)
                    begin
                        next_rdata[7:0] = ext_data_in[7:0];
                        next_beat = 1'b1;
                        next_addr = ext_addr + `CSB_EXT_ADDR_W'(1);
                        next_dout = {8'h00, wdata_q[15:8]};
                        next_cnt = wait_count(act_code);
                    end
                    else
                    begin
                        if (narrow)
                            next_rdata[15:8] = ext_data_in[7:0];
                        else
                            next_rdata = ext_data_in;
                        next_cs_n = 2'b11;
                        next_rd_n = 1'b1;
                        next_wr_n = 1'b1;
                        next_oe = 1'b0;
                        // R02: optional idle cycle before the next access
                        if (cfg[blk].dummy)
                            next_state = csb_pkg::CSB_ST_DUMMY;
                        else
                        begin
                            next_ack = 1'b1;
                            next_busy = 1'b0;
                            next_state = csb_pkg::CSB_ST_IDLE;
                        end
                    end
                end
            end
            csb_pkg::CSB_ST_DUMMY:
            begin
                next_ack = 1'b1;
                next_busy = 1'b0;
                next_state = csb_pkg::CSB_ST_IDLE;
            end
            default:
            begin
                next_busy = 1'b0;
                next_state = csb_pkg::CSB_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= csb_pkg::CSB_ST_IDLE;
            blk <= 1'b0;
            cnt <= 3'h0;
            beat <= 1'b0;
            wdata_q <= 16'h0000;
            mem_ack <= 1'b0;
            mem_miss <= 1'b0;
            mem_busy <= 1'b0;
            mem_rdata <= 16'h0000;
            ext_cs_n <= 2'h3;
            ext_rd_n <= 1'b1;
            ext_wr_n <= 1'b1;
            ext_addr <= 24'h000000;
            ext_data_out <= 16'h0000;
            ext_data_oe <= 1'b0;
        end
        else
        begin
            state <= next_state;
            blk <= next_blk;
            cnt <= next_cnt;
            beat <= next_beat;
            wdata_q <= next_wdata_q;
            mem_ack <= next_ack;
            mem_miss <= next_miss;
            mem_busy <= next_busy;
            mem_rdata <= next_rdata;
            ext_cs_n <= next_cs_n;
            ext_rd_n <= next_rd_n;
            ext_wr_n <= next_wr_n;
            ext_addr <= next_addr;
            ext_data_out <= next_dout;
            ext_data_oe <= next_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port

    logic [7:0] next_reg_rdata;
    // Control registers are write-only and read as zero
    always_comb
    begin
        next_reg_rdata = 8'h00;
        if (reg_read && (reg_addr == `CSB_OFS_STATUS))
            next_reg_rdata = {4'h0, ~ext_cs_n, mem_miss, mem_busy};
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= next_reg_rdata;
    end

endmodule // csb_chip_select

`default_nettype wire

// [csb_params.svh]
`ifndef CSB_PARAMS_SVH
`define CSB_PARAMS_SVH

// Register offsets on the plain register port
`define CSB_REG_ADDR_W 9
`define CSB_OFS_B2_LOW 9'h148
`define CSB_OFS_B2_HIGH 9'h149
`define CSB_OFS_B3_LOW 9'h14c
`define CSB_OFS_B3_HIGH 9'h14d
`define CSB_OFS_B2_START 9'h150
`define CSB_OFS_B2_MASK 9'h151
`define CSB_OFS_B3_START 9'h152
`define CSB_OFS_B3_MASK 9'h153
`define CSB_OFS_STATUS 9'h154

// Control register high fields
`define CSB_HI_ENABLE 7
`define CSB_HI_AREA_MODE 6
`define CSB_HI_ZERO_BIT 5
`define CSB_HI_DUMMY 4
`define CSB_HI_TYPE_LSB 2
`define CSB_HI_BUS_LSB 0

// Control register low fields
`define CSB_LO_WW_LSB 4
`define CSB_LO_WR_LSB 0

// Reset values
`define CSB_RST_HIGH 8'h00
`define CSB_RST_LOW 8'h77
`define CSB_RST_START 8'h00
`define CSB_RST_MASK 8'hff

// Bus width codes
`define CSB_BUS_8 2'h0
`define CSB_BUS_16 2'h1

// Wait codes and their counts
`define CSB_WAIT_CODE_0 3'h1
`define CSB_WAIT_CODE_1 3'h2
`define CSB_WAIT_CODE_2 3'h5
`define CSB_WAIT_CODE_3 3'h6
`define CSB_WAIT_CODE_4 3'h7
`define CSB_WAIT_CODE_PIN 3'h3

// External bus
`define CSB_EXT_ADDR_W 24
`define CSB_AREA_HI_LSB 16
`define CSB_NUM_BLOCKS 2

`endif

// [csb_pkg.sv]
`default_nettype none

package csb_pkg;

    typedef enum logic [1:0] {
        CSB_ST_IDLE = 2'b00,
        CSB_ST_ACCESS = 2'b01,
        CSB_ST_DUMMY = 2'b10
    } csb_state_t;

    typedef struct packed {
        logic enable;
        logic area_mode;
        logic dummy;
        logic [1:0] mem_type;
        logic [1:0] bus_width;
        logic [2:0] write_wait;
        logic [2:0] read_wait;
        logic [7:0] area_start;
        logic [7:0] area_mask;
    } csb_cfg_t;

    typedef struct packed {
        logic [23:0] addr;
        logic write;
        logic [15:0] wdata;
    } csb_req_t;

endpackage

`default_nettype wire

// [csb_chip_select_assertions.sv]
`include "csb_params.svh"
`default_nettype none

module csb_chip_select_checker (
    input wire logic clock, // System clock
    input wire logic arst_n, // Async reset, active low
    input wire logic mem_req, // Access request
    input wire logic mem_ack, // Access finished
    input wire logic mem_miss, // No block hit
    input wire logic mem_busy, // Access running
    input wire logic [1:0] ext_cs_n, // Chip selects
    input wire logic ext_rd_n, // Read strobe
    input wire logic ext_wr_n, // Write strobe
    input wire logic ext_data_oe // Data drive enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dflt @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    cs_onehot_a: assert property (ext_cs_n != 2'h0)
        else $error("both chip selects active");
    miss_idle_a: assert property (
        mem_ack && mem_miss |-> ext_cs_n == 2'h3 && $past(ext_cs_n) == 2'h3)
        else $error("chip select moved on a miss");
    ack_release_a: assert property (
        mem_ack |-> ext_cs_n == 2'h3 && ext_rd_n && ext_wr_n && !ext_data_oe)
        else $error("pins still driven at completion");
    busy_end_a: assert property ($fell(mem_busy) |-> mem_ack)
        else $error("busy dropped without completion");
    busy_cause_a: assert property ($rose(mem_busy) |-> $past(mem_req))
        else $error("busy without request");
    ack_bound_a: assert property (
        mem_req && !mem_busy && !mem_ack |-> ##[1:20] mem_ack)
        else $error("access never completed");
    strobe_cs_a: assert property (!ext_rd_n || !ext_wr_n |-> ext_cs_n != 2'h3)
        else $error("strobe without chip select");
    rd_wr_excl_a: assert property (!(!ext_rd_n && !ext_wr_n))
        else $error("read and write strobe together");
    oe_write_a: assert property (ext_data_oe |-> !ext_wr_n && ext_rd_n)
        else $error("data driven outside a write");
endmodule // csb_chip_select_checker

bind csb_chip_select csb_chip_select_checker csb_chip_select_checker_inst (
    .clock(clock), .arst_n(arst_n), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_miss(mem_miss), .mem_busy(mem_busy), .ext_cs_n(ext_cs_n),
    .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_data_oe(ext_data_oe));

`default_nettype wire

// [csb_memory_model.sv]
`default_nettype none

module csb_memory_model (
    input wire logic clock, // System clock
    input wire logic wide, // 16-bit bus in use
    input wire logic [1:0] ext_cs_n, // Chip selects
    input wire logic ext_rd_n, // Read strobe
    input wire logic ext_wr_n, // Write strobe
    input wire logic [23:0] ext_addr, // Address
    input wire logic [15:0] ext_data_out, // Data from device
    output logic [15:0] ext_data_in, // Data to device
    output logic ext_wait_n // Wait pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256];
    logic [15:0] last;
    logic [7:0] lo;
    logic sel;

    assign sel = ext_cs_n != 2'h3;
    assign lo = ext_addr[7:0];
    assign ext_wait_n = 1'b1;
    // Released bus flips each cycle, so a late sample never reads as data
    assign ext_data_in = !(sel && !ext_rd_n) ? ~last
        : wide ? {mem[lo + 8'h1], mem[lo]} : {~last[15:8], mem[lo]};

    initial
    begin
        last = 16'h0000;
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0] ^ 8'h3c;
    end

    always @(posedge clock)
    begin
        last <= ext_data_in;
        if (sel && !ext_wr_n)
        begin
            mem[lo] <= ext_data_out[7:0];
            if (wide)
                mem[lo + 8'h1] <= ext_data_out[15:8];
        end
    end
endmodule // csb_memory_model

`default_nettype wire

// [csb_chip_select_tb.sv]
`include "csb_params.svh"
`default_nettype none

module csb_chip_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [`CSB_REG_ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic mem_req = 1'b0;
    csb_pkg::csb_req_t mem_req_data = '0;
    logic mem_ack, mem_miss, mem_busy, ext_rd_n, ext_wr_n, ext_data_oe, ext_wait_n;
    logic [15:0] mem_rdata, ext_data_out, ext_data_in;
    logic [1:0] ext_cs_n;
    logic [23:0] ext_addr;
    logic wide = 1'b1;
    int err_total = 0;
    int n_tests = 0;
    logic [7:0] ref_mem [256];
    logic [2:0] wait_tbl [5] = '{3'h1, 3'h5, 3'h7, 3'h2, 3'h6};
    int wait_cnt [8] = '{0, 0, 1, 0, 0, 2, 3, 4};

    always #20 clock = ~clock;

    csb_chip_select csb_chip_select_inst (.clock(clock), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .mem_req(mem_req),
        .mem_req_data(mem_req_data), .mem_ack(mem_ack), .mem_miss(mem_miss),
        .mem_busy(mem_busy), .mem_rdata(mem_rdata), .ext_cs_n(ext_cs_n),
        .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_addr(ext_addr),
        .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
        .ext_data_in(ext_data_in), .ext_wait_n(ext_wait_n));
    csb_memory_model csb_memory_model_inst (.clock(clock), .wide(wide),
        .ext_cs_n(ext_cs_n), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
        .ext_addr(ext_addr), .ext_data_out(ext_data_out),
        .ext_data_in(ext_data_in), .ext_wait_n(ext_wait_n));

    ////////////////////////////////////////
    task automatic print_verdict;
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        check({8'h00, reg_rdata}, {8'h00, exp}, "register read");
    endtask

    // Latency counts edges from the request cycle to the completion cycle
    task automatic mem_op(input logic wr, input logic [23:0] a, input logic [15:0] d,
                          input int lat, input logic miss);
        int n;
        logic [15:0] exp;
        exp = miss ? 16'h0000 : {ref_mem[a[7:0] + 8'h1], ref_mem[a[7:0]]};
        @(posedge clock);
        mem_req <= 1'b1;
        mem_req_data <= '{addr: a, write: wr, wdata: d};
        n = 0;
        do
        begin
            @(posedge clock);
            mem_req <= 1'b0;
            n++;
            @(negedge clock);
        end while (!mem_ack && n < 40);
        check(16'(n), 16'(lat), "latency");
        check({15'h0, mem_miss}, {15'h0, miss}, "miss flag");
        if (!wr)
            check(mem_rdata, exp, "read data");
        else if (!miss)
        begin
            ref_mem[a[7:0]] = d[7:0];
            ref_mem[a[7:0] + 8'h1] = d[15:8];
        end
        if (!mem_ack)
            print_verdict();
    endtask

    ////////////////////////////////////////
    initial
    begin
        logic [23:0] a;
        logic [15:0] d;
        int w;
        int r;
        void'($urandom(32'h1423));
        for (int i = 0; i < 256; i++)
            ref_mem[i] = i[7:0] ^ 8'h3c;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        reg_rd(`CSB_OFS_STATUS, 8'h00);
        reg_rd(`CSB_OFS_B3_LOW, 8'h00);
        reg_rd(9'h1ff, 8'h00);
        mem_op(1'b0, 24'h123456, 16'h0000, 1, 1'b1);
        reg_rd(`CSB_OFS_STATUS, 8'h02);
        for (int bw = 0; bw < 2; bw++)
            for (int dm = 0; dm < 2; dm++)
                for (int i = 0; i < 5; i++)
                begin
                    wide <= bw[0];
                    reg_wr(`CSB_OFS_B3_HIGH, {2'h2, 1'b0, dm[0], 3'h0, bw[0]});
                    reg_wr(`CSB_OFS_B3_LOW, {1'b0, wait_tbl[i], 1'b0, wait_tbl[(i + 1) % 5]});
                    w = wait_cnt[wait_tbl[i]];
                    r = wait_cnt[wait_tbl[(i + 1) % 5]];
                    a = 24'($urandom());
                    d = 16'($urandom());
                    mem_op(1'b1, a, d, bw ? 2 + w + dm : 3 + 2 * w + dm, 1'b0);
                    mem_op(1'b0, a, 16'h0000, bw ? 2 + r + dm : 3 + 2 * r + dm, 1'b0);
                end
        // Block 2 keeps its reset wait setting of four waits
        wide <= 1'b1;
        reg_wr(`CSB_OFS_B3_HIGH, 8'h81);
        reg_wr(`CSB_OFS_B3_LOW, 8'h11);
        reg_wr(`CSB_OFS_B2_HIGH, 8'hc1);
        reg_wr(`CSB_OFS_B2_START, 8'h12);
        reg_wr(`CSB_OFS_B2_MASK, 8'h00);
        a = 24'($urandom());
        mem_op(1'b0, {8'h12, a[15:0]}, 16'h0000, 6, 1'b0);
        mem_op(1'b0, {8'h34, a[15:0]}, 16'h0000, 2, 1'b0);
        reg_wr(`CSB_OFS_B3_HIGH, 8'h01);
        mem_op(1'b0, {8'h34, a[15:0]}, 16'h0000, 1, 1'b1);
        mem_op(1'b1, {8'h12, a[15:0]}, d, 6, 1'b0);
        mem_op(1'b0, {8'h12, a[15:0]}, 16'h0000, 6, 1'b0);
        print_verdict();
    end
endmodule // csb_chip_select_tb

`default_nettype wire
